/* File: design/lcgs_map.svh */
/*
   Register offsets, field positions and reset values of the gate input
   selection block. Assumes a 32-bit bus with byte addresses.
*/
`ifndef LCGS_MAP_SVH
`define LCGS_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define LCGS_OFF_GSL 8'h00
`define LCGS_OFF_GSH 8'h04
`define LCGS_OFF_POL 8'h08
`define LCGS_OFF_SEL 8'h0c
`define LCGS_OFF_STAT 8'h10

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LCGS_TRUE_OFS 1
`define LCGS_INV_OFS 0
`define LCGS_GATE_W 8
`define LCGS_MUXSEL_STEP 4
`define LCGS_MUXSEL_W 3
`define LCGS_STAT_DS_LSB 4
`define LCGS_SEL_MASK 16'h7777

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LCGS_GSL_RST 16'h0000
`define LCGS_GSH_RST 16'h0000
`define LCGS_POL_RST 4'h0
`define LCGS_SEL_RST 16'h0000

// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define LCGS_GATE_LAT 1

`endif

/* File: design/lcgs_pkg.sv */
/*
   Types and shared functions of the gate input selection block.
   Assumes lcgs_map.svh is on the include path.
*/
`include "lcgs_map.svh"

package lcgs_pkg;

   // ------------------------------------------------------------
   // Register selector
   // ------------------------------------------------------------
   typedef enum logic [2:0] {REG_GSL, REG_GSH, REG_POL, REG_SEL, REG_STAT, REG_NONE} lcgs_reg_t;

   function automatic lcgs_reg_t lcgs_decode(input logic [7:0] a);
      if (a == `LCGS_OFF_GSL) begin
         return REG_GSL;
      end else if (a == `LCGS_OFF_GSH) begin
         return REG_GSH;
      end else if (a == `LCGS_OFF_POL) begin
         return REG_POL;
      end else if (a == `LCGS_OFF_SEL) begin
         return REG_SEL;
      end else if (a == `LCGS_OFF_STAT) begin
         return REG_STAT;
      end else begin
         return REG_NONE;
      end
   endfunction : lcgs_decode

   // True/inverted pair per source, source 4 pair on top
   function automatic logic [7:0] lcgs_expand(input logic [3:0] ds);
      logic [7:0] v;
      v = 8'h00;
      for (int s = 0; s < 4; s++) begin
         v[2*s+`LCGS_TRUE_OFS] = ds[s];
         v[2*s+`LCGS_INV_OFS] = ~ds[s];
      end
      return v;
   endfunction : lcgs_expand

   // Byte-lane merge for 16-bit registers
   function automatic logic [15:0] lcgs_merge16(input logic [15:0] old,
                                                input logic [15:0] dat,
                                                input logic [1:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         r[15:8] = dat[15:8];
      end
      return r;
   endfunction : lcgs_merge16

endpackage : lcgs_pkg

/* File: design/lcgs_cfg_if.sv */
/*
   Carrier between the register side and the selection datapath.
   Assumes one clock domain; all members are plain levels.
*/
interface lcgs_cfg_if;
   logic [15:0] gsl;
   logic [15:0] gsh;
   logic [3:0] pol;
   logic [15:0] sel;
   logic [31:0] cand;
   logic [3:0] ds;
   logic [3:0] gate;

   modport ctrl (output gsl, gsh, pol, sel, cand, input ds, gate);
   modport mux (input sel, cand, output ds);
   modport gate_side (input gsl, gsh, pol, ds, output gate);
endinterface : lcgs_cfg_if

/* File: design/lcgs_srcmux.sv */
/*
   Four data-source multiplexers, eight candidates each.
   Assumes candidates are synchronous to the system clock.
*/
module lcgs_srcmux import lcgs_pkg::*; (
   // Configuration and sources
   lcgs_cfg_if.mux cfg
);

   // ------------------------------------------------------------
   // Source selection
   // ------------------------------------------------------------
   genvar m;
   generate
      for (m = 0; m < 4; m++) begin : g_mux
         logic [2:0] pick;
         assign pick = cfg.sel[`LCGS_MUXSEL_STEP*m +: `LCGS_MUXSEL_W];
         assign cfg.ds[m] = cfg.cand[8*m + pick];
      end
   endgenerate

endmodule : lcgs_srcmux

/* File: design/lcgs_gate.sv */
/*
   Four gates: OR of enabled true and inverted terms, then polarity.
   Assumes enables and polarity come from the register side.
*/
module lcgs_gate import lcgs_pkg::*; (
   // Configuration and gate results
   lcgs_cfg_if.gate_side cfg
);

   // ------------------------------------------------------------
   // Gate combine
   // ------------------------------------------------------------
   logic [31:0] en;
   logic [7:0] terms;

   assign en = {cfg.gsh, cfg.gsl};
   assign terms = lcgs_expand(cfg.ds);

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_gate
         // Empty enable byte gives low before polarity
         assign cfg.gate[g] = cfg.pol[g] ^ (|(en[`LCGS_GATE_W*g +: `LCGS_GATE_W] & terms));
      end
   endgenerate

endmodule : lcgs_gate

/* File: design/lcgs_top.sv */
/*
   Gate input selection stage of a logic cell, with a classic Wishbone
   register slave. Assumes one synchronous clock, synchronous inputs
   and a master that holds each request until ack or err.
*/
// Added by the designer: the register addresses and register access over Wishbone.
// ------------------------------------------------------------
// Overview of operation
// - Low register bits 7..0 feed gate 1
// - True enable passes source into the gate
// - Inverted enable passes complemented source into gate
// - Bit 8 low register: gate 2 source 1 inverted
// - High register bits 15..8 feed gate 4
// - High register bits 7..0 feed gate 3
// - High register read/write, clears at reset
// - Gate polarity control inverts gate output
// - Each source from its own 3-bit mux
// ------------------------------------------------------------
module lcgs_top import lcgs_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Source candidates, eight per mux
   input wire logic [31:0] src_cand,
   // Cell side
   output logic [3:0] gate_out,
   output logic [3:0] data_src
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   lcgs_cfg_if cfg ();

   logic [15:0] gsl_q;
   logic [15:0] gsh_q;
   logic [3:0] pol_q;
   logic [15:0] sel_q;
   logic [3:0] gate_out_q;
   logic [3:0] data_src_q;
   logic [31:0] dat_q;
   logic ack_q;
   logic err_q;
   logic req;
   logic wr;
   lcgs_reg_t hit;
   logic [31:0] rd_d;
   logic [7:0] pair_ref;

   // ------------------------------------------------------------
   // Datapath
   // ------------------------------------------------------------
   assign cfg.gsl = gsl_q;
   assign cfg.gsh = gsh_q;
   assign cfg.pol = pol_q;
   assign cfg.sel = sel_q;
   assign cfg.cand = src_cand;

   lcgs_srcmux u_mux (
      .cfg(cfg.mux)
   );

   lcgs_gate u_gate (
      .cfg(cfg.gate_side)
   );

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // A request is taken once; ack or err then blocks it for a cycle
   assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
   assign hit = lcgs_decode(wb_adr_i);
   assign wr = req && wb_we_i && (hit != REG_NONE);

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         gsl_q <= `LCGS_GSL_RST;
      end else if (wr && hit == REG_GSL) begin
         gsl_q <= lcgs_merge16(gsl_q, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         gsh_q <= `LCGS_GSH_RST;
      end else if (wr && hit == REG_GSH) begin
         gsh_q <= lcgs_merge16(gsh_q, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pol_q <= `LCGS_POL_RST;
      end else if (wr && hit == REG_POL && wb_sel_i[0]) begin
         pol_q <= wb_dat_i[3:0];
      end
   end

   // Reserved bit above each select field stays zero
   always_ff @(posedge clk) begin
      if (rst) begin
         sel_q <= `LCGS_SEL_RST;
      end else if (wr && hit == REG_SEL) begin
         sel_q <= lcgs_merge16(sel_q, wb_dat_i[15:0], wb_sel_i[1:0]) & `LCGS_SEL_MASK;
      end
   end

   // ------------------------------------------------------------
   // Cell outputs
   // ------------------------------------------------------------
   // Registered so the cell sees glitch-free terms; costs one cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         gate_out_q <= 4'h0;
      end else begin
         gate_out_q <= cfg.gate;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         data_src_q <= 4'h0;
      end else begin
         data_src_q <= cfg.ds;
      end
   end

   assign gate_out = gate_out_q;
   assign data_src = data_src_q;

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always_comb begin
      rd_d = 32'h0000_0000;
      if (hit == REG_GSL) begin
         rd_d[15:0] = gsl_q;
      end else if (hit == REG_GSH) begin
         rd_d[15:0] = gsh_q;
      end else if (hit == REG_POL) begin
         rd_d[3:0] = pol_q;
      end else if (hit == REG_SEL) begin
         rd_d[15:0] = sel_q;
      end else if (hit == REG_STAT) begin
         rd_d[3:0] = gate_out_q;
         rd_d[`LCGS_STAT_DS_LSB +: 4] = data_src_q;
      end
   end

   // ------------------------------------------------------------
   // Bus answer
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         ack_q <= req && (hit != REG_NONE);
         err_q <= req && (hit == REG_NONE);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dat_q <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         dat_q <= rd_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_err_o = err_q;
   assign wb_dat_o = dat_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Reference pairs spelled out by hand, not through the shared helper
   assign pair_ref = {cfg.ds[3], !cfg.ds[3], cfg.ds[2], !cfg.ds[2],
                      cfg.ds[1], !cfg.ds[1], cfg.ds[0], !cfg.ds[0]};

   property p_gate1_low_byte;
      @(posedge clk) disable iff (rst)
      1'b1 |=> gate_out_q[0] == $past(pol_q[0] ^ (|(gsl_q[7:0] & pair_ref)));
   endproperty
   a_gate1_low_byte: assert property (p_gate1_low_byte) else $error("gate 1 mismatch");

   property p_true_term;
      @(posedge clk) disable iff (rst)
      (gsl_q[7:0] == 8'h80 && !pol_q[0]) |=> gate_out_q[0] == $past(cfg.ds[3]);
   endproperty
   a_true_term: assert property (p_true_term) else $error("true term not routed");

   property p_inv_term;
      @(posedge clk) disable iff (rst)
      (gsl_q[7:0] == 8'h01 && !pol_q[0]) |=> gate_out_q[0] == !$past(cfg.ds[0]);
   endproperty
   a_inv_term: assert property (p_inv_term) else $error("inverted term not routed");

   property p_g2_bit8;
      @(posedge clk) disable iff (rst)
      (gsl_q[15:8] == 8'h01 && !pol_q[1]) |=> gate_out_q[1] == !$past(cfg.ds[0]);
   endproperty
   a_g2_bit8: assert property (p_g2_bit8) else $error("gate 2 bit 8 mismatch");

   property p_gate4_high;
      @(posedge clk) disable iff (rst)
      (gsh_q[15:8] == 8'h80 && !pol_q[3]) |=> gate_out_q[3] == $past(cfg.ds[3]);
   endproperty
   a_gate4_high: assert property (p_gate4_high) else $error("gate 4 bit 15 mismatch");

   property p_gate3_bit1;
      @(posedge clk) disable iff (rst)
      (gsh_q[7:0] == 8'h02 && !pol_q[2]) |=> gate_out_q[2] == $past(cfg.ds[0]);
   endproperty
   a_gate3_bit1: assert property (p_gate3_bit1) else $error("gate 3 bit 1 mismatch");

   property p_gsh_write;
      @(posedge clk) disable iff (rst)
      (wr && hit == REG_GSH && wb_sel_i[1:0] == 2'h3) |=> gsh_q == $past(wb_dat_i[15:0]);
   endproperty
   a_gsh_write: assert property (p_gsh_write) else $error("high register write lost");

   property p_gsh_hold;
      @(posedge clk) disable iff (rst)
      !(wr && hit == REG_GSH) |=> $stable(gsh_q);
   endproperty
   a_gsh_hold: assert property (p_gsh_hold) else $error("high register changed unasked");

   property p_polarity;
      @(posedge clk) disable iff (rst)
      (gsl_q[7:0] == 8'h00 && pol_q[0]) |=> gate_out_q[0];
   endproperty
   a_polarity: assert property (p_polarity) else $error("polarity not applied");

   property p_mux_pick;
      @(posedge clk) disable iff (rst)
      1'b1 |=> data_src_q[1] == $past(src_cand[8 + sel_q[6:4]]);
   endproperty
   a_mux_pick: assert property (p_mux_pick) else $error("source 2 mux mismatch");

   property p_empty_gate;
      @(posedge clk) disable iff (rst)
      (gsh_q[15:8] == 8'h00 && !pol_q[3]) [*2] |-> !gate_out_q[3];
   endproperty
   a_empty_gate: assert property (p_empty_gate) else $error("empty gate not low");

   property p_ack_pulse;
      @(posedge clk) disable iff (rst)
      (wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o);
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle");

   property p_gate2_byte;
      @(posedge clk) disable iff (rst)
      1'b1 |=> gate_out_q[1] == $past(pol_q[1] ^ (|(gsl_q[15:8] & pair_ref)));
   endproperty
   a_gate2_byte: assert property (p_gate2_byte) else $error("gate 2 mismatch");

   property p_gate3_byte;
      @(posedge clk) disable iff (rst)
      1'b1 |=> gate_out_q[2] == $past(pol_q[2] ^ (|(gsh_q[7:0] & pair_ref)));
   endproperty
   a_gate3_byte: assert property (p_gate3_byte) else $error("gate 3 mismatch");

   property p_gate4_byte;
      @(posedge clk) disable iff (rst)
      1'b1 |=> gate_out_q[3] == $past(pol_q[3] ^ (|(gsh_q[15:8] & pair_ref)));
   endproperty
   a_gate4_byte: assert property (p_gate4_byte) else $error("gate 4 mismatch");

   property p_gsl_hold;
      @(posedge clk) disable iff (rst)
      !(wr && hit == REG_GSL) |=> $stable(gsl_q);
   endproperty
   a_gsl_hold: assert property (p_gsl_hold) else $error("low register changed unasked");

   property p_pol_hold;
      @(posedge clk) disable iff (rst)
      !(wr && hit == REG_POL) |=> $stable(pol_q);
   endproperty
   a_pol_hold: assert property (p_pol_hold) else $error("polarity changed unasked");

   property p_gsh_read;
      @(posedge clk) disable iff (rst)
      (req && !wb_we_i && hit == REG_GSH) |=> wb_dat_o == {16'h0000, $past(gsh_q)};
   endproperty
   a_gsh_read: assert property (p_gsh_read) else $error("high register read wrong");

   property p_gsh_reset;
      @(posedge clk)
      rst |=> gsh_q == `LCGS_GSH_RST;
   endproperty
   a_gsh_reset: assert property (p_gsh_reset) else $error("high register not cleared");

   property p_sel_reserved;
      @(posedge clk) disable iff (rst)
      1'b1 |-> (sel_q & ~`LCGS_SEL_MASK) == 16'h0000;
   endproperty
   a_sel_reserved: assert property (p_sel_reserved) else $error("reserved select bit set");

   property p_answer_next;
      @(posedge clk) disable iff (rst)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o) |=> (wb_ack_o || wb_err_o);
   endproperty
   a_answer_next: assert property (p_answer_next) else $error("bus answer late");

endmodule : lcgs_top

/* File: bench/tb_lcgs_top.sv */
/*
   Self-checking bench of the gate input selection block: Wishbone
   register access, gate routing, polarity and source muxes.
   Assumes the design files and lcgs_map.svh are compiled before it.
*/
`include "lcgs_map.svh"

module tb_lcgs_top import lcgs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic clk, rst, cyc, stb, we, ack, err;
   logic [7:0] adr;
   logic [3:0] sel, gate_out, data_src;
   logic [31:0] dat_i, dat_o, cand;
   int failures = 0;
   int tests_run = 0;

   lcgs_top u_lcgs_top (
      .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .wb_err_o(err), .src_cand(cand),
      .gate_out(gate_out), .data_src(data_src)
   );

   always #2.5 clk = ~clk;

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // Called just after a rising edge; values read at an edge are pre-edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat_i <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
      if (n >= 20) begin
         check(32'h1, 32'h0, "bus answer missing");
      end
      r = dat_o;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      wb(1'b1, a, d, 4'hf, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] r;
      logic e;
      wb(1'b0, a, 32'h0, 4'hf, r, e);
      check(r, exp, what);
   endtask : rd

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      check(gate_out, 4'h0, "gates after reset");
      rd(`LCGS_OFF_GSL, 32'h0, "low select reset");
      rd(`LCGS_OFF_GSH, 32'h0, "high select reset");
      rd(`LCGS_OFF_POL, 32'h0, "polarity reset");
      rd(`LCGS_OFF_SEL, 32'h0, "mux select reset");
   endtask : t_reset

   task automatic t_regs();
      logic [31:0] r;
      logic e;
      wr(`LCGS_OFF_GSH, 32'hffff_a55a);
      rd(`LCGS_OFF_GSH, 32'h0000_a55a, "high select rw");
      wb(1'b1, `LCGS_OFF_GSH, 32'h0000_3c00, 4'h2, r, e);
      rd(`LCGS_OFF_GSH, 32'h0000_3c5a, "high select upper lane");
      wr(`LCGS_OFF_GSH, 32'h0);
   endtask : t_regs

   // One enable bit at a time over both registers, two source patterns
   task automatic t_route();
      logic [3:0] ds, exp;
      int g, s;
      for (int p = 0; p < 2; p++) begin
         ds = (p == 0) ? 4'h5 : 4'ha;
         cand <= {7'h00, ds[3], 7'h00, ds[2], 7'h00, ds[1], 7'h00, ds[0]};
         for (int b = 0; b < 32; b++) begin
            g = b / 8;
            s = (b % 8) / 2;
            exp = 4'h0;
            if (((b % 2) == 1) ? ds[s] : ~ds[s]) begin
               exp[g] = 1'b1;
            end
            wr(`LCGS_OFF_GSL, (b < 16) ? (32'h1 << b) : 32'h0);
            wr(`LCGS_OFF_GSH, (b >= 16) ? (32'h1 << (b - 16)) : 32'h0);
            repeat (`LCGS_GATE_LAT) @(posedge clk);
            check(gate_out, exp, "gate routing");
            check(data_src, ds, "data sources");
         end
      end
      wr(`LCGS_OFF_GSH, 32'h0);
   endtask : t_route

   task automatic t_pol();
      wr(`LCGS_OFF_POL, 32'h5);
      @(posedge clk);
      check(gate_out, 4'h5, "empty gates inverted");
      // True and inverted term together make gate 1 always high
      wr(`LCGS_OFF_GSL, 32'h0003);
      @(posedge clk);
      check(gate_out, 4'h4, "or of terms inverted");
      wr(`LCGS_OFF_POL, 32'h0);
      @(posedge clk);
      check(gate_out, 4'h1, "or of terms");
      rd(`LCGS_OFF_STAT, 32'h0000_00a1, "status word");
      wr(`LCGS_OFF_GSL, 32'h0);
   endtask : t_pol

   task automatic t_mux();
      logic [7:0] one;
      for (int k = 0; k < 8; k++) begin
         one = 8'h01 << k;
         cand <= {~one, one, ~one, one};
         wr(`LCGS_OFF_SEL, {16'h0, {4{1'b0, 3'(k)}}});
         @(posedge clk);
         check(data_src, 4'h5, "mux code");
      end
      wr(`LCGS_OFF_SEL, 32'hffff_ffff);
      rd(`LCGS_OFF_SEL, 32'h0000_7777, "mux select fields");
   endtask : t_mux

   task automatic t_err();
      logic [31:0] r;
      logic e;
      wr(`LCGS_OFF_GSH, 32'h0000_1234);
      wb(1'b1, 8'h14, 32'h0000_ffff, 4'hf, r, e);
      check(e, 1'b1, "unmapped write error");
      rd(`LCGS_OFF_GSH, 32'h0000_1234, "high select kept");
   endtask : t_err

   // ------------------------------------------------------------
   // Verdict and main sequence
   // ------------------------------------------------------------
   task automatic print_verdict();
      if (failures == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat_i = 32'h0;
      cand = 32'h0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_regs();
      t_route();
      t_pol();
      t_mux();
      t_err();
      print_verdict();
   end

   // Whole run needs well under a thousand bus cycles
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      print_verdict();
   end
endmodule : tb_lcgs_top
